//--- rtl/skew_meas.sv
// skew measurement processor with axi4-lite register access
// Summary of operation
// - reference source chosen by five-bit selector
// - measurement source chosen by five-bit selector
// - four-bit window sets both averaging counts
// - offset window is two to (setting+1)
// - drift window same, capped at 16
// - sliding average over newest N samples
// - full-window flags in top result bytes
// - flag set once the window holds N samples, and kept while it stays full
// - offset is 62-bit signed over eight bytes
// - offset lsb is 2^-16 picosecond
// - skew-updated event bit on new result
// - unit interval is averaged reference period
// - offset folded into plus/minus half UI
// - drift is 62-bit signed after offset
// - drift is offset change per UI
// - equal frequencies give zero drift
// - drift beyond UI/16 sets limit event
// - reference tags-only ignores untagged stamps
// - measurement tags-only ignores untagged stamps
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module skew_meas (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // time stamp sources, units of 2^-16 ps
  input wire logic [skew_meas_pkg::NSRC-1:0] ts_valid,
  input wire logic [skew_meas_pkg::NSRC-1:0] ts_tag,
  input wire logic [skew_meas_pkg::NSRC*skew_meas_pkg::TS_W-1:0] ts_time,
  // axi4-lite write address
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    logic [7:0] window;
    logic [7:0] ref_sel;
    logic [7:0] meas_sel;
    logic [skew_meas_pkg::TS_W-1:0] last_ref;
    logic ref_seen;
    logic [skew_meas_pkg::TS_W-1:0] ui;
    logic ui_ok;
    logic [skew_meas_pkg::RES_W-1:0] prev_skew;
    logic prev_ok;
    logic [skew_meas_pkg::SUM_W-1:0] off_sum;
    logic [skew_meas_pkg::CNT_W-1:0] off_cnt;
    logic [skew_meas_pkg::OFF_DEPTH_LOG-1:0] off_wp;
    logic [skew_meas_pkg::SUM_W-1:0] dr_sum;
    logic [skew_meas_pkg::CNT_W-1:0] dr_cnt;
    logic [skew_meas_pkg::DRIFT_DEPTH_LOG-1:0] dr_wp;
    logic [skew_meas_pkg::RES_W-1:0] off_res;
    logic [skew_meas_pkg::RES_W-1:0] dr_res;
    logic off_full;
    logic dr_full;
    logic ev_upd;
    logic ev_lim;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // sample histories; no reset needed, the running sums track what is valid
  logic [skew_meas_pkg::RES_W-1:0] off_mem [0:(1<<skew_meas_pkg::OFF_DEPTH_LOG)-1];
  logic [skew_meas_pkg::RES_W-1:0] dr_mem [0:(1<<skew_meas_pkg::DRIFT_DEPTH_LOG)-1];
  logic off_we;
  logic dr_we;
  logic [skew_meas_pkg::RES_W-1:0] off_wdata;
  logic [skew_meas_pkg::RES_W-1:0] dr_wdata;

  // floor of log2 for partial-window averages
  function automatic logic [4:0] flog2(input logic [skew_meas_pkg::CNT_W-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < skew_meas_pkg::CNT_W; i++)
      if (v[i])
        r = 5'(i);
    return r;
  endfunction : flog2

  // byte k of a result word, full flag in bit 7 of the top byte
  function automatic logic [7:0] res_byte(input logic [skew_meas_pkg::RES_W-1:0] v,
                                          input logic full, input logic [2:0] k);
    logic [63:0] w;
    w = {full, 1'b0, v};
    return w[{k, 3'h0} +: 8];
  endfunction : res_byte

  always_comb
  begin
    logic [13:0] widx;
    logic [13:0] ridx;
    logic restart;
    logic [4:0] rsel;
    logic [4:0] msel;
    logic ref_take;
    logic meas_take;
    logic [skew_meas_pkg::TS_W-1:0] rtime;
    logic [skew_meas_pkg::TS_W-1:0] mtime;
    logic signed [skew_meas_pkg::TS_W-1:0] raw;
    logic signed [skew_meas_pkg::TS_W-1:0] half;
    logic [skew_meas_pkg::TS_W-1:0] period;
    logic [skew_meas_pkg::RES_W-1:0] samp;
    logic [skew_meas_pkg::RES_W-1:0] dsamp;
    logic signed [skew_meas_pkg::RES_W-1:0] dmag;
    logic [4:0] nlog;
    logic [4:0] dlog;
    logic [skew_meas_pkg::CNT_W-1:0] nwin;
    logic [skew_meas_pkg::CNT_W-1:0] dwin;
    logic [4:0] sh;
    logic [skew_meas_pkg::SUM_W-1:0] old_ext;
    logic [skew_meas_pkg::SUM_W-1:0] new_ext;
    logic [skew_meas_pkg::RES_W-1:0] off_old;
    logic [skew_meas_pkg::RES_W-1:0] dr_old;
    logic [7:0] rbyte;
    logic rhit;
    logic lim_hit;
    nxt_st = st_ff;
    lim_hit = 1'b0;
    widx = s_axi_awaddr[15:2];
    ridx = s_axi_araddr[15:2];
    restart = 1'b0;
    rsel = st_ff.ref_sel[skew_meas_pkg::SEL_LSB +: skew_meas_pkg::SEL_W];
    msel = st_ff.meas_sel[skew_meas_pkg::SEL_LSB +: skew_meas_pkg::SEL_W];
    rtime = ts_time[{rsel, 6'h00} +: skew_meas_pkg::TS_W];
    mtime = ts_time[{msel, 6'h00} +: skew_meas_pkg::TS_W];
    ref_take = ts_valid[rsel] &
      (ts_tag[rsel] | ~st_ff.ref_sel[skew_meas_pkg::TAGS_ONLY_BIT]);
    meas_take = ts_valid[msel] &
      (ts_tag[msel] | ~st_ff.meas_sel[skew_meas_pkg::TAGS_ONLY_BIT]);
    raw = '0;
    half = '0;
    period = '0;
    samp = '0;
    dsamp = '0;
    dmag = '0;
    sh = 5'h00;
    old_ext = '0;
    new_ext = '0;
    off_old = off_mem[st_ff.off_wp];
    dr_old = dr_mem[st_ff.dr_wp];
    rbyte = 8'h00;
    rhit = 1'b1;
    off_we = 1'b0;
    dr_we = 1'b0;
    off_wdata = '0;
    dr_wdata = '0;
    nlog = 5'({1'b0, st_ff.window[skew_meas_pkg::WIN_W-1:0]}) + 5'h01;
    dlog = (nlog > 5'(skew_meas_pkg::DRIFT_DEPTH_LOG)) ?
      5'(skew_meas_pkg::DRIFT_DEPTH_LOG) : nlog;
    nwin = skew_meas_pkg::CNT_W'(1) << nlog;
    dwin = skew_meas_pkg::CNT_W'(1) << dlog;

    // measurement stamp against the latest reference edge
    if (meas_take && st_ff.ref_seen && st_ff.ui_ok)
    begin
      raw = mtime - st_ff.last_ref;
      half = st_ff.ui >> 1;
      if (raw > half)
        raw = raw - st_ff.ui;
      else if (raw < -half)
        raw = raw + st_ff.ui;
      samp = raw[skew_meas_pkg::RES_W-1:0];
      // offset: ring of N samples, oldest dropped once full
      off_we = 1'b1;
      off_wdata = samp;
      new_ext = skew_meas_pkg::SUM_W'(signed'(samp));
      old_ext = skew_meas_pkg::SUM_W'(signed'(off_old));
      if (st_ff.off_cnt == nwin)
      begin
        nxt_st.off_sum = st_ff.off_sum - old_ext + new_ext;
      end
      else
      begin
        nxt_st.off_sum = st_ff.off_sum + new_ext;
        nxt_st.off_cnt = st_ff.off_cnt + 1'b1;
      end
      nxt_st.off_wp = (st_ff.off_wp + 1'b1) & (nwin[15:0] - 16'h0001);
      sh = (nxt_st.off_cnt == nwin) ? nlog : flog2(nxt_st.off_cnt);
      nxt_st.off_res = skew_meas_pkg::RES_W'(signed'(nxt_st.off_sum) >>> sh);
      nxt_st.off_full = (nxt_st.off_cnt == nwin);
      nxt_st.ev_upd = 1'b1;
      // drift: change in offset since the previous sample
      if (st_ff.prev_ok)
      begin
        dsamp = samp - st_ff.prev_skew;
        dr_we = 1'b1;
        dr_wdata = dsamp;
        new_ext = skew_meas_pkg::SUM_W'(signed'(dsamp));
        old_ext = skew_meas_pkg::SUM_W'(signed'(dr_old));
        if (st_ff.dr_cnt == dwin)
        begin
          nxt_st.dr_sum = st_ff.dr_sum - old_ext + new_ext;
        end
        else
        begin
          nxt_st.dr_sum = st_ff.dr_sum + new_ext;
          nxt_st.dr_cnt = st_ff.dr_cnt + 1'b1;
        end
        nxt_st.dr_wp = (st_ff.dr_wp + 1'b1) & (dwin[3:0] - 4'h1);
        sh = (nxt_st.dr_cnt == dwin) ? dlog : flog2(nxt_st.dr_cnt);
        nxt_st.dr_res = skew_meas_pkg::RES_W'(signed'(nxt_st.dr_sum) >>> sh);
        nxt_st.dr_full = (nxt_st.dr_cnt == dwin);
        dmag = dsamp[skew_meas_pkg::RES_W-1] ? -signed'(dsamp) : signed'(dsamp);
        if (skew_meas_pkg::TS_W'(dmag) > (st_ff.ui >> skew_meas_pkg::LIMIT_SHIFT))
        begin
          nxt_st.ev_lim = 1'b1;
          lim_hit = 1'b1;
        end
      end
      nxt_st.prev_skew = samp;
      nxt_st.prev_ok = 1'b1;
    end

    // reference edge: coarse running average of its period
    if (ref_take)
    begin
      nxt_st.last_ref = rtime;
      nxt_st.ref_seen = 1'b1;
      if (st_ff.ref_seen)
      begin
        period = rtime - st_ff.last_ref;
        nxt_st.ui_ok = 1'b1;
        nxt_st.ui = st_ff.ui_ok ?
          st_ff.ui + ts_shr(period - st_ff.ui) : period;
      end
    end

    // register write: both channels taken on the same edge
    if (s_axi_awvalid && s_axi_wvalid && !st_ff.bvalid)
    begin
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = skew_meas_pkg::RESP_OKAY;
      if (s_axi_awaddr[1:0] != 2'h0)
        nxt_st.bresp = skew_meas_pkg::RESP_SLVERR;
      else if (widx == skew_meas_pkg::IDX_WINDOW)
      begin
        if (s_axi_wstrb[0])
        begin
          nxt_st.window = s_axi_wdata[7:0];
          restart = 1'b1;
        end
      end
      else if (widx == skew_meas_pkg::IDX_REF_SEL)
      begin
        if (s_axi_wstrb[0])
        begin
          nxt_st.ref_sel = s_axi_wdata[7:0];
          restart = 1'b1;
        end
      end
      else if (widx == skew_meas_pkg::IDX_MEAS_SEL)
      begin
        if (s_axi_wstrb[0])
        begin
          nxt_st.meas_sel = s_axi_wdata[7:0];
          restart = 1'b1;
        end
      end
      else if (widx == skew_meas_pkg::IDX_EVENT_STATUS)
      begin
        // write one to clear; a new event in this cycle still wins
        if (s_axi_wstrb[0] && s_axi_wdata[skew_meas_pkg::UPDATED_BIT] && !off_we)
          nxt_st.ev_upd = 1'b0;
      end
      else if (widx == skew_meas_pkg::IDX_EVENT_LIMIT)
      begin
        // a limit hit in this cycle survives the clear, even when the bit was already set
        if (s_axi_wstrb[0] && s_axi_wdata[skew_meas_pkg::LIMIT_BIT] && !lim_hit)
          nxt_st.ev_lim = 1'b0;
      end
      else if (!((widx >= skew_meas_pkg::IDX_OFFSET_LO) &&
                 (widx < skew_meas_pkg::IDX_DRIFT_LO + 14'(skew_meas_pkg::RESULT_BYTES))))
        nxt_st.bresp = skew_meas_pkg::RESP_SLVERR;
    end
    else if (st_ff.bvalid && s_axi_bready)
      nxt_st.bvalid = 1'b0;

    // a new configuration throws away every partial average
    if (restart)
    begin
      nxt_st.ref_seen = 1'b0;
      nxt_st.ui_ok = 1'b0;
      nxt_st.prev_ok = 1'b0;
      nxt_st.off_sum = '0;
      nxt_st.off_cnt = '0;
      nxt_st.off_wp = '0;
      nxt_st.dr_sum = '0;
      nxt_st.dr_cnt = '0;
      nxt_st.dr_wp = '0;
      nxt_st.off_full = 1'b0;
      nxt_st.dr_full = 1'b0;
      off_we = 1'b0;
      dr_we = 1'b0;
    end

    // register read
    if (s_axi_arvalid && !st_ff.rvalid)
    begin
      if (ridx == skew_meas_pkg::IDX_WINDOW)
        rbyte = {4'h0, st_ff.window[skew_meas_pkg::WIN_W-1:0]};
      else if (ridx == skew_meas_pkg::IDX_REF_SEL)
        rbyte = {2'h0, st_ff.ref_sel[5:0]};
      else if (ridx == skew_meas_pkg::IDX_MEAS_SEL)
        rbyte = {2'h0, st_ff.meas_sel[5:0]};
      else if (ridx == skew_meas_pkg::IDX_EVENT_STATUS)
        rbyte = 8'(st_ff.ev_upd) << skew_meas_pkg::UPDATED_BIT;
      else if (ridx == skew_meas_pkg::IDX_EVENT_LIMIT)
        rbyte = 8'(st_ff.ev_lim) << skew_meas_pkg::LIMIT_BIT;
      else if ((ridx >= skew_meas_pkg::IDX_OFFSET_LO) && (ridx < skew_meas_pkg::IDX_DRIFT_LO))
        rbyte = res_byte(st_ff.off_res, st_ff.off_full,
                         3'(ridx - skew_meas_pkg::IDX_OFFSET_LO));
      else if ((ridx >= skew_meas_pkg::IDX_DRIFT_LO) &&
               (ridx < skew_meas_pkg::IDX_DRIFT_LO + 14'(skew_meas_pkg::RESULT_BYTES)))
        rbyte = res_byte(st_ff.dr_res, st_ff.dr_full,
                         3'(ridx - skew_meas_pkg::IDX_DRIFT_LO));
      else
        rhit = 1'b0;
      if (s_axi_araddr[1:0] != 2'h0)
        rhit = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = {24'h000000, rhit ? rbyte : 8'h00};
      nxt_st.rresp = rhit ? skew_meas_pkg::RESP_OKAY : skew_meas_pkg::RESP_SLVERR;
    end
    else if (st_ff.rvalid && s_axi_rready)
      nxt_st.rvalid = 1'b0;
  end

  // arithmetic shift for the reference period filter
  function automatic logic [skew_meas_pkg::TS_W-1:0] ts_shr(
    input logic [skew_meas_pkg::TS_W-1:0] v);
    return skew_meas_pkg::TS_W'(signed'(v) >>> skew_meas_pkg::UI_AVG_SHIFT);
  endfunction : ts_shr

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
      st_ff.window <= skew_meas_pkg::WINDOW_RST;
      st_ff.ref_sel <= skew_meas_pkg::SEL_RST;
      st_ff.meas_sel <= skew_meas_pkg::SEL_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (off_we)
      off_mem[st_ff.off_wp] <= off_wdata;
    if (dr_we)
      dr_mem[st_ff.dr_wp] <= dr_wdata;
  end

  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~st_ff.bvalid;
  assign s_axi_wready = s_axi_awvalid & s_axi_wvalid & ~st_ff.bvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = ~st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

endmodule : skew_meas

//--- rtl/skew_meas_pkg.sv
// constants for the skew measurement processor
package skew_meas_pkg;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_WINDOW = 14'h2a14;
  localparam logic [13:0] IDX_REF_SEL = 14'h2a15;
  localparam logic [13:0] IDX_MEAS_SEL = 14'h2a16;
  localparam logic [13:0] IDX_OFFSET_LO = 14'h3a2c;
  localparam logic [13:0] IDX_DRIFT_LO = 14'h3a34;
  localparam logic [13:0] IDX_EVENT_LIMIT = 14'h300c;
  localparam logic [13:0] IDX_EVENT_STATUS = 14'h300f;
  localparam int RESULT_BYTES = 8;
  // field positions
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 5;
  localparam int TAGS_ONLY_BIT = 5;
  localparam int WIN_W = 4;
  localparam int FULL_BIT = 63;
  localparam int UPDATED_BIT = 4;
  localparam int LIMIT_BIT = 5;
  // reset values
  localparam logic [7:0] WINDOW_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  // data path sizes
  localparam int NSRC = 32;
  localparam int TS_W = 64;
  localparam int RES_W = 62;
  localparam int SUM_W = 80;
  localparam int OFF_DEPTH_LOG = 16;
  localparam int DRIFT_DEPTH_LOG = 4;
  localparam int CNT_W = 17;
  // reference period smoothing and drift limit shifts
  localparam int UI_AVG_SHIFT = 3;
  localparam int LIMIT_SHIFT = 4;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : skew_meas_pkg

//--- sim/skew_meas_monitor.sv
// assertion checker on the register port of the skew processor
`timescale 1ns/1ps
module skew_meas_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register bus
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [13:0] ridx_ff;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) ridx_ff <= 14'h0000;
    else if (s_axi_arvalid && s_axi_arready) ridx_ff <= s_axi_araddr[15:2];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  off_top_a: assert property (s_axi_rvalid && ridx_ff == skew_meas_pkg::IDX_OFFSET_LO + 14'h7 |-> !s_axi_rdata[6])
    else $error("offset top byte bit 6 set");
  drift_top_a: assert property (s_axi_rvalid && ridx_ff == skew_meas_pkg::IDX_DRIFT_LO + 14'h7 |-> !s_axi_rdata[6])
    else $error("drift top byte bit 6 set");
  byte_pad_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  sel_okay_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr[15:2] == skew_meas_pkg::IDX_REF_SEL |=> s_axi_bresp == skew_meas_pkg::RESP_OKAY)
    else $error("reference select write refused");
endmodule : skew_meas_monitor

bind skew_meas skew_meas_monitor mon (.sys_clk(sys_clk), .reset_n(reset_n),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

//--- sim/ts_source_model.sv
// time stamp sources feeding the skew processor
`timescale 1ns/1ps
module ts_source_model (
  // clock
  input wire logic sys_clk,
  // time stamp outputs
  output logic [31:0] ts_valid,
  output logic [31:0] ts_tag,
  output logic [2047:0] ts_time
);
  initial
  begin
    ts_valid = '0;
    ts_tag = '0;
    ts_time = '0;
  end
  // after the pulse the slot shows the inverse, so a stale time is never mistaken for data
  task automatic stamp(input int src, input logic tag, input logic [63:0] t);
    ts_valid[src] <= 1'h1;
    ts_tag[src] <= tag;
    ts_time[64*src+:64] <= t;
    @(posedge sys_clk);
    ts_valid[src] <= 1'h0;
    ts_tag[src] <= ~tag;
    ts_time[64*src+:64] <= ~t;
    @(posedge sys_clk);
  endtask : stamp
endmodule : ts_source_model

//--- sim/skew_meas_tb.sv
// self-checking bench for the skew measurement processor
`timescale 1ns/1ps
module skew_meas_tb;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [31:0] ts_valid, ts_tag, s_axi_rdata;
  logic [2047:0] ts_time;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail = 0, samples_checked = 0, seed = 32'hcda9e42a;
  int rsel, msel, nwin, ndr, nsk;
  logic lim = 1'h0;
  longint ui, tref, sk_q[$], dr_q[$];
  always #12.5 sys_clk = ~sys_clk;
  skew_meas dut (.sys_clk(sys_clk), .reset_n(reset_n), .ts_valid(ts_valid), .ts_tag(ts_tag),
    .ts_time(ts_time), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  ts_source_model src (.sys_clk(sys_clk), .ts_valid(ts_valid), .ts_tag(ts_tag), .ts_time(ts_time));
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do @(posedge sys_clk); while (!(s_axi_awready === 1'h1 && s_axi_wready === 1'h1));
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    s_axi_bready <= 1'h1;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [13:0] idx, output logic [31:0] d, output logic [1:0] resp);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic rd_res(input logic [13:0] idx, output logic [63:0] v);
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 8; i++)
    begin
      rd(idx + 14'(i), d, r);
      v[8*i+:8] = d[7:0];
    end
  endtask : rd_res
  // partial averages shift by floor(log2(count)) until the window is full
  function automatic logic [63:0] avg(longint q[$], logic full);
    longint sum = 0;
    int k = 0;
    foreach (q[i]) sum += q[i];
    while ((2 << k) <= q.size()) k++;
    return {full, 1'h0, 62'(sum >>> k)};
  endfunction : avg
  task automatic restart(input int w);
    wr(skew_meas_pkg::IDX_WINDOW, 8'(w));
    nwin = 2 << w;
    ndr = nwin > 16 ? 16 : nwin;
    nsk = 0;
    sk_q.delete();
    dr_q.delete();
    repeat (2)
    begin
      tref += ui;
      src.stamp(rsel, 1'h1, tref);
    end
  endtask : restart
  task automatic step(input longint s, input logic tonly);
    longint f, dd;
    logic [63:0] v;
    tref += ui;
    if (tonly) src.stamp(rsel, 1'h0, ~tref);
    src.stamp(rsel, 1'h1, tref);
    src.stamp((rsel + 3) % 32, 1'h1, ~tref);
    if (tonly) src.stamp(msel, 1'h0, tref);
    src.stamp(msel, 1'h1, tref + s);
    f = s > ui / 2 ? s - ui : (s < -ui / 2 ? s + ui : s);
    if (nsk > 0)
    begin
      dd = f - sk_q[$];
      dr_q.push_back(dd);
      if ((dd < 0 ? -dd : dd) > (ui >>> 4)) lim = 1'h1;
      if (dr_q.size() > ndr) void'(dr_q.pop_front());
    end
    sk_q.push_back(f);
    nsk++;
    if (sk_q.size() > nwin) void'(sk_q.pop_front());
    rd_res(skew_meas_pkg::IDX_OFFSET_LO, v);
    check(v, avg(sk_q, nsk >= nwin), "offset");
    rd_res(skew_meas_pkg::IDX_DRIFT_LO, v);
    if (nsk > 1) check(v, avg(dr_q, nsk > ndr), "drift");
  endtask : step
  task automatic events;
    logic [31:0] d;
    logic [1:0] r;
    rd(skew_meas_pkg::IDX_EVENT_STATUS, d, r);
    check(64'(d[4]), 64'h1, "updated");
    wr(skew_meas_pkg::IDX_EVENT_STATUS, 8'h10);
    rd(skew_meas_pkg::IDX_EVENT_STATUS, d, r);
    check(64'(d[4]), 64'h0, "updated clear");
    rd(skew_meas_pkg::IDX_EVENT_LIMIT, d, r);
    check(64'(d[5]), 64'(lim), "limit");
    wr(skew_meas_pkg::IDX_EVENT_LIMIT, 8'h20);
    lim = 1'h0;
  endtask : events
  initial
  begin
    #(25 * 40000);
    n_fail++;
    conclude();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++)
    begin
      rd(skew_meas_pkg::IDX_WINDOW + 14'(i), d, r);
      check({30'h0, r, d}, 64'h0, "reset value");
    end
    rd(14'h0001, d, r);
    check(64'(r), 64'(skew_meas_pkg::RESP_SLVERR), "unmapped");
    // only the low nibble of the window register reads back
    wr(skew_meas_pkg::IDX_WINDOW, 8'hff);
    rd(skew_meas_pkg::IDX_WINDOW, d, r);
    check(64'(d), 64'h0f, "window field");
    ui = {32'h0000000f, $random(seed)};
    tref = {$random(seed), $random(seed)};
    for (int w = 0; w < 5; w++)
    begin
      rsel = $random(seed) & 31;
      msel = (rsel + 7) % 32;
      wr(skew_meas_pkg::IDX_REF_SEL, 8'(rsel));
      wr(skew_meas_pkg::IDX_MEAS_SEL, 8'(msel));
      restart(w);
      repeat (nwin + 2) step(longint'($random(seed)), 1'h0);
      events();
    end
    // skew beyond half a period must fold negative and give zero drift
    wr(skew_meas_pkg::IDX_REF_SEL, 8'(rsel | 32));
    wr(skew_meas_pkg::IDX_MEAS_SEL, 8'(msel | 32));
    restart(1);
    repeat (6) step(ui - 64'h1234, 1'h1);
    events();
    conclude();
  end
endmodule : skew_meas_tb
